//--- src/lbx_pkg.sv
package lbx_pkg;

    localparam logic [7:0] OPC_AND_LITERAL = 8'hB5;
    localparam logic [6:0] OPC_AND_REGISTER = 7'h05;
    localparam logic [4:0] OPC_BIT_CLEAR = 5'h11;
    localparam int DEST_BIT = 8;
    localparam logic [7:0] ACC_RESET = 8'h00;

    typedef enum logic [1:0]
    {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_EXECUTE = 2'b11,
        PH_WRITE   = 2'b10
    } lbx_phase_t;

    typedef enum logic [1:0]
    {
        OP_NONE    = 2'h0,
        OP_ANDLIT  = 2'h1,
        OP_ANDREG  = 2'h2,
        OP_BITCLR  = 2'h3
    } lbx_op_t;

    typedef struct packed
    {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } lbx_fwrite_t;

endpackage : lbx_pkg

//--- src/lbx_exec.sv
`timescale 1ns/1ps
module lbx_exec
    import lbx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [15:0] instrWord,
    input  wire logic [7:0]  fileRdData,
    input  wire logic        accLoadEn,
    input  wire logic [7:0]  accLoadData,
    output logic [7:0]       fileRdAddr,
    output lbx_fwrite_t      fileWrite,
    output logic [7:0]       workingAccumulator,
    output logic             zeroFlag,
    output lbx_phase_t       phase,
    output logic             cycleDone
);

    lbx_phase_t  phase_reg, phase_next;
    lbx_op_t     op_reg, op_next;
    logic [15:0] instr_reg, instr_next;
    logic [7:0]  operand_reg, operand_next;
    logic [7:0]  result_reg, result_next;
    logic [7:0]  acc_reg, acc_next;
    logic        zero_reg, zero_next;
    lbx_fwrite_t fw_reg, fw_next;

    lbx_op_t decoded;
    logic    destFile;
    logic [2:0] bitSel;

    always_comb
    begin
        // Decoded from the live word; only the decode phase latches it
        if (instrWord[15:8] == OPC_AND_LITERAL)
            decoded = OP_ANDLIT;
        else if (instrWord[15:9] == OPC_AND_REGISTER)
            decoded = OP_ANDREG;
        else if (instrWord[15:11] == OPC_BIT_CLEAR)
            decoded = OP_BITCLR;
        else
            decoded = OP_NONE;
    end

    assign destFile = instr_reg[DEST_BIT];
    assign bitSel   = instr_reg[10:8];

    always_comb
    begin
        phase_next   = phase_reg;
        op_next      = op_reg;
        instr_next   = instr_reg;
        operand_next = operand_reg;
        result_next  = result_reg;
        acc_next     = acc_reg;
        zero_next    = zero_reg;
        // Strobe defaults low every cycle so a write lasts exactly one cycle
        fw_next      = '0;
        unique case (phase_reg)
            PH_DECODE:
            begin
                instr_next = instrWord;
                op_next    = decoded;
                phase_next = PH_READ;
                // Outside loads land only here, so an op in flight sees a steady accumulator
                if (accLoadEn)
                    acc_next = accLoadData;
            end
            PH_READ:
            begin
                // Literal comes from the word, every other op from the file
                operand_next = (op_reg == OP_ANDLIT) ? instr_reg[7:0] : fileRdData;
                phase_next   = PH_EXECUTE;
            end
            PH_EXECUTE:
            begin
                unique case (op_reg)
                    OP_ANDLIT,
                    OP_ANDREG: result_next = acc_reg & operand_reg;
                    OP_BITCLR: result_next = operand_reg & ~(8'h01 << bitSel);
                    OP_NONE:   result_next = operand_reg;
                endcase
                phase_next = PH_WRITE;
            end
            PH_WRITE:
            begin
                unique case (op_reg)
                    OP_ANDLIT:
                    begin
                        acc_next  = result_reg;
                        zero_next = (result_reg == 8'h00);
                    end
                    OP_ANDREG:
                    begin
                        zero_next = (result_reg == 8'h00);
                        if (destFile)
                            fw_next = '{en: 1'b1, addr: instr_reg[7:0], data: result_reg};
                        else
                            acc_next = result_reg;
                    end
                    OP_BITCLR:
                        fw_next = '{en: 1'b1, addr: instr_reg[7:0], data: result_reg};
                    OP_NONE:
                        fw_next = '0;
                endcase
                phase_next = PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            phase_reg   <= PH_DECODE;
            op_reg      <= OP_NONE;
            instr_reg   <= 16'h0000;
            operand_reg <= 8'h00;
            result_reg  <= 8'h00;
            acc_reg     <= ACC_RESET;
            zero_reg    <= 1'b0;
            fw_reg      <= '0;
        end
        else
        begin
            phase_reg   <= phase_next;
            op_reg      <= op_next;
            instr_reg   <= instr_next;
            operand_reg <= operand_next;
            result_reg  <= result_next;
            acc_reg     <= acc_next;
            zero_reg    <= zero_next;
            fw_reg      <= fw_next;
        end
    end

    assign fileRdAddr         = instr_reg[7:0];
    assign fileWrite          = fw_reg;
    assign workingAccumulator = acc_reg;
    assign zeroFlag           = zero_reg;
    assign phase              = phase_reg;
    // Combinational so the core can advance its fetch in the same cycle
    assign cycleDone          = (phase_reg == PH_WRITE);

    a_phase_order: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_DECODE |=> phase_reg == PH_READ ##1 phase_reg == PH_EXECUTE
        ##1 phase_reg == PH_WRITE ##1 phase_reg == PH_DECODE)
        else $error("phase sequence broken");

    a_andlit_result: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_ANDLIT |=>
        acc_reg == ($past(acc_reg, 3) & instr_reg[7:0]) && !fw_reg.en)
        else $error("literal and result wrong");

    a_andreg_zero: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_ANDREG |=> zero_reg == ($past(result_reg) == 8'h00))
        else $error("zero flag wrong");

    a_dest_file: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_ANDREG && destFile |=>
        fw_reg.en && $stable(acc_reg) && fw_reg.data == $past(result_reg))
        else $error("file destination wrong");

    a_dest_acc: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_ANDREG && !destFile |=>
        !fw_reg.en && acc_reg == $past(result_reg))
        else $error("accumulator destination wrong");

    a_addr_pass: assert property (@(posedge clk) disable iff (srst)
        fw_reg.en |-> fw_reg.addr == $past(instr_reg[7:0]))
        else $error("write address wrong");

    a_bitclr_flags: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_BITCLR |=>
        $stable(zero_reg) && $stable(acc_reg) && fw_reg.data[$past(bitSel)] == 1'b0)
        else $error("bit clear wrong");

    a_write_phase: assert property (@(posedge clk) disable iff (srst)
        fw_reg.en |-> $past(phase_reg) == PH_WRITE)
        else $error("write outside write phase");

    a_acc_load: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_DECODE && accLoadEn |=> acc_reg == $past(accLoadData))
        else $error("accumulator load lost");

    a_andlit_zero: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_ANDLIT |=> zero_reg == (acc_reg == 8'h00))
        else $error("literal and zero flag wrong");

    // Checks the AND itself instead of trusting the execute register
    a_andreg_data: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_ANDREG |=>
        (fw_reg.en ? fw_reg.data : acc_reg) == ($past(acc_reg) & $past(operand_reg)))
        else $error("register and result wrong");

    // Every bit but the selected one must come back as it was read
    a_bitclr_others: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_BITCLR |=>
        fw_reg.en && (fw_reg.data | (8'h01 << $past(bitSel))) ==
        ($past(operand_reg) | (8'h01 << $past(bitSel))))
        else $error("bit clear touched other bits");

    a_fw_pulse: assert property (@(posedge clk) disable iff (srst)
        fw_reg.en |=> !fw_reg.en)
        else $error("write strobe longer than one cycle");

    a_rd_addr: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_READ |-> fileRdAddr == $past(instrWord[7:0]))
        else $error("read address wrong");

    a_none_quiet: assert property (@(posedge clk) disable iff (srst)
        phase_reg == PH_WRITE && op_reg == OP_NONE |=>
        !fw_reg.en && $stable(acc_reg) && $stable(zero_reg))
        else $error("unknown op changed state");

endmodule : lbx_exec

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import lbx_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] instrWord = 16'h0000;
    logic [7:0]  fileRdData = 8'h00;
    logic        accLoadEn = 1'b0;
    logic [7:0]  accLoadData = 8'h00;
    logic [7:0]  fileRdAddr;
    lbx_fwrite_t fileWrite;
    logic [7:0]  workingAccumulator;
    logic        zeroFlag;
    lbx_phase_t  phase;
    logic        cycleDone;
    logic [7:0]  mem [256];
    logic [7:0]  mAcc = ACC_RESET;
    logic        mZero = 1'b0;
    lbx_fwrite_t mWr = '0;
    int          err_total = 0;
    int          tests_run = 0;

    always #2.5 clk = ~clk;

    lbx_exec i_dut (
        .clk                (clk),
        .srst               (srst),
        .instrWord          (instrWord),
        .fileRdData         (fileRdData),
        .accLoadEn          (accLoadEn),
        .accLoadData        (accLoadData),
        .fileRdAddr         (fileRdAddr),
        .fileWrite          (fileWrite),
        .workingAccumulator (workingAccumulator),
        .zeroFlag           (zeroFlag),
        .phase              (phase),
        .cycleDone          (cycleDone)
    );

    task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // Bench copy of the file keeps read-after-write between ops honest
    function automatic void predict(logic [15:0] w, logic ld, logic [7:0] ldData);
        logic [7:0] r;
        r = mem[w[7:0]];
        mWr = '0;
        // A load lands in decode, ahead of the op's own operand read
        if (ld)
            mAcc = ldData;
        if (w[15:8] == OPC_AND_LITERAL)
        begin
            mAcc = mAcc & w[7:0];
            mZero = (mAcc == 8'h00);
        end
        else if (w[15:9] == OPC_AND_REGISTER)
        begin
            r = r & mAcc;
            mZero = (r == 8'h00);
            if (w[DEST_BIT])
                mWr = '{1'b1, w[7:0], r};
            else
                mAcc = r;
        end
        else if (w[15:11] == OPC_BIT_CLEAR)
        begin
            r[w[10:8]] = 1'b0;
            mWr = '{1'b1, w[7:0], r};
        end
        if (mWr.en) mem[w[7:0]] = r;
    endfunction : predict

    // One op per four cycles; results of the previous op are seen in c0
    task automatic op(logic [15:0] w, logic ld = 1'b0, logic [7:0] ldData = 8'h00);
        @(posedge clk);
        srst <= 1'b0;
        instrWord <= w;
        fileRdData <= mem[w[7:0]];
        accLoadEn <= ld;
        accLoadData <= ldData;
        @(negedge clk);
        chk("phase", 17'(PH_DECODE), 17'(phase));
        chk("acc", 17'(mAcc), 17'(workingAccumulator));
        chk("zero", 17'(mZero), 17'(zeroFlag));
        chk("fwrite", 17'(mWr), 17'(fileWrite));
        predict(w, ld, ldData);
        @(negedge clk);
        chk("rdaddr", 17'(w[7:0]), 17'(fileRdAddr));
        repeat (2) @(negedge clk);
        chk("done", 17'h00001, 17'(cycleDone));
    endtask : op

    // Reset in mid-run; the last op's results are checked before they are wiped
    task automatic pulse_reset;
        @(posedge clk);
        srst <= 1'b1;
        @(negedge clk);
        chk("acc", 17'(mAcc), 17'(workingAccumulator));
        chk("zero", 17'(mZero), 17'(zeroFlag));
        chk("fwrite", 17'(mWr), 17'(fileWrite));
        mAcc = ACC_RESET;
        mZero = 1'b0;
        mWr = '0;
        @(posedge clk);
    endtask : pulse_reset

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        int          k;
        logic [15:0] w;
        void'($urandom(32'h4865));
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (19) @(posedge clk);
        op(16'h0000);
        $display("test reset done");
        op({OPC_AND_LITERAL, 8'h5F}, 1'b1, 8'hA3);
        op({OPC_AND_LITERAL, 8'hF0}, 1'b1, 8'h0F);
        op({OPC_AND_REGISTER, 1'b0, 8'h00}, 1'b1, 8'hFF);
        op({OPC_AND_REGISTER, 1'b1, 8'hFF}, 1'b1, 8'hC3);
        op({OPC_AND_REGISTER, 1'b0, 8'h40}, 1'b1, 8'h7E);
        pulse_reset();
        op({OPC_AND_LITERAL, 8'hFF});
        op({OPC_BIT_CLEAR, 3'h7, 8'hFF});
        for (int b = 0; b < 8; b++) op({OPC_BIT_CLEAR, 3'(b), 8'(b + 8'h80)});
        $display("test corner done");
        repeat (200)
        begin
            k = $urandom_range(3);
            w = 16'($urandom);
            if (k == 0) w[15:8] = OPC_AND_LITERAL;
            else if (k == 1) w[15:9] = OPC_AND_REGISTER;
            else if (k == 2) w[15:11] = OPC_BIT_CLEAR;
            op(w, 1'($urandom), 8'($urandom));
            if ($urandom_range(15) == 0)
                pulse_reset();
        end
        op(16'h0000);
        $display("test random done");
        wrap_up();
    end
endmodule : testbench
